// ---- inc/flag_unit_defines.vh ----
`ifndef FLAG_UNIT_DEFINES_VH
`define FLAG_UNIT_DEFINES_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL       8'h00
`define OFS_OPERAND_A  8'h04
`define OFS_OPERAND_B  8'h08
`define OFS_CMD        8'h0C
`define OFS_FLAGS      8'h10
`define OFS_RESULT_A   8'h14
`define OFS_RESULT_B   8'h18
`define OFS_RESULT_C   8'h1C
`define OFS_RESULT_D   8'h20
`define OFS_FPU_CTRL   8'h24
`define OFS_FPU_STAT   8'h28
`define OFS_FPU_INFP   8'h2C
`define OFS_FPU_INFN   8'h30
`define OFS_IRQ_STAT   8'h34
`define OFS_IRQ_CLEAR  8'h38
`define OFS_IRQ_EN     8'h3C

// ----------------------------------------
// status flag register bit positions
// ----------------------------------------
`define FLG_CF    0
`define FLG_RSV1  1
`define FLG_PF    2
`define FLG_AF    4
`define FLG_ZF    6
`define FLG_SF    7
`define FLG_TF    8
`define FLG_IF    9
`define FLG_DF    10
`define FLG_OF    11
`define FLG_IOPL0 12
`define FLG_IOPL1 13
`define FLG_NT    14
`define FLG_B15   15
`define FLG_RF    16
`define FLG_AC    18
`define FLG_ID    21
`define FLAGS_RESET 32'h00000002
// bits a flag load copies through the mask (cf pf af zf sf tf if df of nt); iopl, ac and id are loaded separately
`define FLAGS_LOAD_MASK 32'h00004FD5

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_CPL_LO 0
`define CTRL_CPL_HI 1
`define CTRL_PMODE  2

// ----------------------------------------
// command codes
// ----------------------------------------
`define OP_NOP       4'h0
`define OP_AND       4'h1
`define OP_ADD       4'h2
`define OP_ADC       4'h3
`define OP_FLAG_LOAD 4'h4
`define OP_QUERY     4'h5
`define OP_FPU_INIT  4'h6
`define OP_CLC       4'h7
`define OP_STC       4'h8
`define OP_CMC       4'h9

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_DONE  0
`define IRQ_FAULT 1
`define IRQ_IO_PRIVILEGE_FIELD  2
`define IRQ_BITS  3

// ----------------------------------------
// floating-point unit init values
// ----------------------------------------
`define FPU_CW_INIT  16'h037F
`define FPU_SW_INIT  16'h0000
`define FPU_TW_INIT  16'hFFFF
`define FPU_INF_POS  32'h7F800000
`define FPU_INF_NEG  32'hFF800000

`endif

// ---- core/flag_alu.v ----
`default_nettype none

module flag_alu #(
   parameter WIDTH = 32
) (
   input  wire [WIDTH-1:0] a,
   input  wire [WIDTH-1:0] b,
   input  wire             cin,
   input  wire             do_and,
   output wire [WIDTH-1:0] res,
   output wire             cf,
   output wire             of,
   output wire             af,
   output wire             zf,
   output wire             sf,
   output wire             pf
);

   wire [WIDTH:0] sum;

   assign sum = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
   assign res = do_and ? (a & b) : sum[WIDTH-1:0];
   assign cf  = do_and ? 1'b0 : sum[WIDTH];
   assign of  = do_and ? 1'b0 : ((a[WIDTH-1] == b[WIDTH-1]) && (res[WIDTH-1] != a[WIDTH-1]));
   assign af  = a[4] ^ b[4] ^ res[4];
   assign zf  = (res == {WIDTH{1'b0}});
   assign sf  = res[WIDTH-1];
   // even parity of the low byte
   assign pf  = ~^res[7:0];

endmodule // flag_alu

`default_nettype wire

// ---- core/query_rom.v ----
`default_nettype none

module query_rom #(
   parameter [31:0] MAX_LEAF   = 32'h00000002,
   // vendor words: arbitrary neutral text, not a real maker
   parameter [31:0] VENDOR_B   = 32'h6D617845,
   parameter [31:0] VENDOR_D   = 32'h43656C70,
   parameter [31:0] VENDOR_C   = 32'h5865726F,
   // signature and feature values: arbitrary
   parameter [31:0] SIGNATURE  = 32'h00000610,
   parameter [31:0] BRAND_IDX  = 32'h00000001,
   parameter [31:0] FEATURE_C  = 32'h00000000,
   parameter [31:0] FEATURE_D  = 32'h00000001,
   parameter [31:0] CACHE_DESC = 32'h00000001
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [31:0] leaf,
   output reg  [31:0] out_a,
   output reg  [31:0] out_b,
   output reg  [31:0] out_c,
   output reg  [31:0] out_d
);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_a <= 32'h00000000;
         out_b <= 32'h00000000;
         out_c <= 32'h00000000;
         out_d <= 32'h00000000;
      end
      else
      begin
         case (leaf)
            32'h00000000:
            begin
               out_a <= MAX_LEAF;
               out_b <= VENDOR_B;
               out_c <= VENDOR_C;
               out_d <= VENDOR_D;
            end
            32'h00000001:
            begin
               out_a <= SIGNATURE;
               out_b <= BRAND_IDX;
               out_c <= FEATURE_C;
               out_d <= FEATURE_D;
            end
            32'h00000002:
            begin
               out_a <= CACHE_DESC;
               out_b <= 32'h00000000;
               out_c <= 32'h00000000;
               out_d <= 32'h00000000;
            end
            default:
            begin
               out_a <= 32'h00000000;
               out_b <= 32'h00000000;
               out_c <= 32'h00000000;
               out_d <= 32'h00000000;
            end
         endcase
      end
   end

endmodule // query_rom

`default_nettype wire

// ---- core/status_flag_unit.v ----
// The implementer's own choices: the APB register port and the placing of the registers.
`include "flag_unit_defines.vh"
`default_nettype none

module status_flag_unit #(
   parameter QUERY_SUPPORTED = 1,
   parameter AC_IMPLEMENTED  = 1,
   parameter FPU_PRESENT     = 1,
   parameter FPU_LATER_TYPE  = 1
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire        irq,
   output reg         invalid_opcode_fault
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [2:0]  ctrl_reg;
   reg  [31:0] accumulator_reg_a;
   reg  [31:0] operand_b_reg;
   reg  [31:0] status_flag_reg;
   reg  [31:0] result_reg_a;
   reg  [31:0] result_reg_b;
   reg  [31:0] result_reg_c;
   reg  [31:0] result_reg_d;
   reg  [15:0] fpu_cw_reg;
   reg  [15:0] fpu_sw_reg;
   reg  [15:0] fpu_tw_reg;
   reg         fpu_valid_reg;
   reg  [2:0]  irq_stat_reg;
   reg  [2:0]  irq_en_reg;

   reg  [31:0] flag_next;
   reg  [31:0] result_next;
   reg         result_load;
   reg         query_load;
   reg         fpu_init;
   reg         fault_next;
   reg         io_privilege_field_refused;
   reg         addr_ok;

   wire        wr_en;
   wire        rd_en;
   wire        cmd_we;
   wire [3:0]  opcode;
   wire [1:0]  current_privilege_level;
   wire        pmode;
   wire [1:0]  io_privilege_field;
   wire        do_and;
   wire        cin;
   wire [31:0] alu_res;
   wire        alu_cf;
   wire        alu_of;
   wire        alu_af;
   wire        alu_zf;
   wire        alu_sf;
   wire        alu_pf;
   wire [31:0] q_a;
   wire [31:0] q_b;
   wire [31:0] q_c;
   wire [31:0] q_d;
   wire [2:0]  irq_events;
   wire [2:0]  irq_clear;

   assign wr_en  = psel & penable & pwrite;
   assign rd_en  = psel & ~pwrite;
   assign cmd_we = wr_en & (paddr == `OFS_CMD);
   assign opcode = pwdata[3:0];
   assign current_privilege_level    = ctrl_reg[`CTRL_CPL_HI:`CTRL_CPL_LO];
   assign pmode  = ctrl_reg[`CTRL_PMODE];
   assign io_privilege_field   = status_flag_reg[`FLG_IOPL1:`FLG_IOPL0];
   assign do_and = (opcode == `OP_AND);
   assign cin    = (opcode == `OP_ADC) & status_flag_reg[`FLG_CF];

   // ----------------------------------------
   // datapath and query table
   // ----------------------------------------
   flag_alu #(
      .WIDTH (32)
   ) u_alu (
      .a      (accumulator_reg_a),
      .b      (operand_b_reg),
      .cin    (cin),
      .do_and (do_and),
      .res    (alu_res),
      .cf     (alu_cf),
      .of     (alu_of),
      .af     (alu_af),
      .zf     (alu_zf),
      .sf     (alu_sf),
      .pf     (alu_pf)
   );

   // table output follows the selector one cycle later
   query_rom u_rom (
      .pclk    (pclk),
      .presetn (presetn),
      .leaf    (accumulator_reg_a),
      .out_a   (q_a),
      .out_b   (q_b),
      .out_c   (q_c),
      .out_d   (q_d)
   );

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   always @*
   begin
      flag_next    = status_flag_reg;
      result_next  = alu_res;
      result_load  = 1'b0;
      query_load   = 1'b0;
      fpu_init     = 1'b0;
      fault_next   = 1'b0;
      io_privilege_field_refused = 1'b0;
      case (opcode)
         `OP_NOP:
         begin
            result_load = 1'b0;
         end
         `OP_AND:
         begin
            result_load           = 1'b1;
            flag_next[`FLG_OF]    = 1'b0;
            flag_next[`FLG_CF]    = 1'b0;
            flag_next[`FLG_SF]    = alu_sf;
            flag_next[`FLG_ZF]    = alu_zf;
            flag_next[`FLG_PF]    = alu_pf;
         end
         `OP_ADD, `OP_ADC:
         begin
            result_load           = 1'b1;
            flag_next[`FLG_OF]    = alu_of;
            flag_next[`FLG_SF]    = alu_sf;
            flag_next[`FLG_ZF]    = alu_zf;
            flag_next[`FLG_AF]    = alu_af;
            flag_next[`FLG_PF]    = alu_pf;
            flag_next[`FLG_CF]    = alu_cf;
         end
         `OP_FLAG_LOAD:
         begin
            // restore from accumulator image; resume flag untouched
            flag_next = (status_flag_reg & ~`FLAGS_LOAD_MASK)
                        | (accumulator_reg_a & `FLAGS_LOAD_MASK);
            if (!pmode || current_privilege_level == 2'b00)
               flag_next[`FLG_IOPL1:`FLG_IOPL0] = accumulator_reg_a[`FLG_IOPL1:`FLG_IOPL0];
            else
               io_privilege_field_refused = (accumulator_reg_a[`FLG_IOPL1:`FLG_IOPL0] != io_privilege_field);
            if (pmode && (current_privilege_level > io_privilege_field))
               flag_next[`FLG_IF] = status_flag_reg[`FLG_IF];
            if (AC_IMPLEMENTED != 0)
               flag_next[`FLG_AC] = accumulator_reg_a[`FLG_AC];
            if (QUERY_SUPPORTED != 0)
               flag_next[`FLG_ID] = accumulator_reg_a[`FLG_ID];
         end
         `OP_QUERY:
         begin
            if (QUERY_SUPPORTED != 0)
               query_load = 1'b1;
            else
               fault_next = 1'b1;
         end
         `OP_FPU_INIT:
         begin
            if (FPU_PRESENT != 0)
               fpu_init = 1'b1;
            else
               fault_next = 1'b1;
         end
         `OP_CLC:
            flag_next[`FLG_CF] = 1'b0;
         `OP_STC:
            flag_next[`FLG_CF] = 1'b1;
         `OP_CMC:
            flag_next[`FLG_CF] = ~status_flag_reg[`FLG_CF];
         default:
            fault_next = 1'b1;
      endcase
      // fixed bits; undefined results stay deterministic
      flag_next[`FLG_RSV1] = 1'b1;
      flag_next[`FLG_B15]  = 1'b0;
   end

   // ----------------------------------------
   // register writes and command execution
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg             <= 3'h0;
         accumulator_reg_a    <= 32'h00000000;
         operand_b_reg        <= 32'h00000000;
         status_flag_reg      <= `FLAGS_RESET;
         result_reg_a         <= 32'h00000000;
         result_reg_b         <= 32'h00000000;
         result_reg_c         <= 32'h00000000;
         result_reg_d         <= 32'h00000000;
         fpu_cw_reg           <= 16'h0000;
         fpu_sw_reg           <= 16'h0000;
         fpu_tw_reg           <= 16'h0000;
         fpu_valid_reg        <= 1'b0;
         invalid_opcode_fault <= 1'b0;
      end
      else
      begin
         invalid_opcode_fault <= cmd_we & fault_next;
         if (wr_en && paddr == `OFS_CTRL)
            ctrl_reg <= pwdata[2:0];
         if (wr_en && paddr == `OFS_OPERAND_A)
            accumulator_reg_a <= pwdata;
         if (wr_en && paddr == `OFS_OPERAND_B)
            operand_b_reg <= pwdata;
         if (cmd_we)
         begin
            status_flag_reg <= flag_next;
            if (result_load)
               result_reg_a <= result_next;
            if (query_load)
            begin
               result_reg_a <= q_a;
               result_reg_b <= q_b;
               result_reg_c <= q_c;
               result_reg_d <= q_d;
            end
            if (fpu_init)
            begin
               fpu_cw_reg    <= `FPU_CW_INIT;
               fpu_sw_reg    <= `FPU_SW_INIT;
               fpu_tw_reg    <= `FPU_TW_INIT;
               fpu_valid_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // interrupts: set wins over clear
   // ----------------------------------------
   assign irq_events = {cmd_we & io_privilege_field_refused,
                        cmd_we & fault_next,
                        cmd_we & ~fault_next};
   assign irq_clear  = (wr_en && paddr == `OFS_IRQ_CLEAR) ? pwdata[2:0] : 3'h0;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= 3'h0;
         irq_en_reg   <= 3'h0;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_events;
         if (wr_en && paddr == `OFS_IRQ_EN)
            irq_en_reg <= pwdata[2:0];
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ----------------------------------------
   // apb read and response
   // ----------------------------------------
   always @*
   begin
      addr_ok = 1'b1;
      case (paddr)
         `OFS_CTRL, `OFS_OPERAND_A, `OFS_OPERAND_B, `OFS_CMD, `OFS_FLAGS,
         `OFS_RESULT_A, `OFS_RESULT_B, `OFS_RESULT_C, `OFS_RESULT_D,
         `OFS_FPU_CTRL, `OFS_FPU_STAT, `OFS_FPU_INFP, `OFS_FPU_INFN,
         `OFS_IRQ_STAT, `OFS_IRQ_CLEAR, `OFS_IRQ_EN:
            addr_ok = 1'b1;
         default:
            addr_ok = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_en && !penable)
      begin
         case (paddr)
            `OFS_CTRL:      prdata <= {29'h00000000, ctrl_reg};
            `OFS_OPERAND_A: prdata <= accumulator_reg_a;
            `OFS_OPERAND_B: prdata <= operand_b_reg;
            `OFS_FLAGS:     prdata <= status_flag_reg;
            `OFS_RESULT_A:  prdata <= result_reg_a;
            `OFS_RESULT_B:  prdata <= result_reg_b;
            `OFS_RESULT_C:  prdata <= result_reg_c;
            `OFS_RESULT_D:  prdata <= result_reg_d;
            `OFS_FPU_CTRL:  prdata <= {fpu_tw_reg, fpu_cw_reg};
            `OFS_FPU_STAT:  prdata <= {15'h0000, fpu_valid_reg, fpu_sw_reg};
            `OFS_FPU_INFP:  prdata <= fpu_valid_reg ? `FPU_INF_POS : 32'h00000000;
            `OFS_FPU_INFN:
               prdata <= !fpu_valid_reg ? 32'h00000000 :
                         (FPU_LATER_TYPE != 0) ? `FPU_INF_NEG : `FPU_INF_POS;
            `OFS_IRQ_STAT:  prdata <= {29'h00000000, irq_stat_reg};
            `OFS_IRQ_EN:    prdata <= {29'h00000000, irq_en_reg};
            default:        prdata <= 32'h00000000;
         endcase
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

endmodule // status_flag_unit

`default_nettype wire

// ---- tb/status_flag_unit_chk.sv ----
`default_nettype none
module status_flag_unit_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        invalid_opcode_fault
);
   timeunit 1ns;
   timeprecision 1ps;
   wire bad_addr;
   wire rd_acc;
   wire cmd_wr;
   assign bad_addr = (paddr > 8'h3C) || (paddr[1:0] != 2'b00);
   assign rd_acc = psel && penable && !pwrite;
   assign cmd_wr = psel && penable && pwrite && (paddr == 8'h0C);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SLVERR_MAP: assert property (pslverr == (psel && penable && bad_addr))
      else $error("pslverr does not follow address decode");
   AST_UNMAPPED_ZERO: assert property (rd_acc && bad_addr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_FAULT_OPCODE: assert property (cmd_wr && pwdata[3:0] > 4'h9 |=> invalid_opcode_fault)
      else $error("unknown opcode gave no fault");
   AST_NO_FAULT_LEGAL: assert property (cmd_wr && pwdata[3:0] <= 4'h4 |=> !invalid_opcode_fault)
      else $error("legal opcode faulted");
   AST_FAULT_PULSE: assert property (invalid_opcode_fault |=> !invalid_opcode_fault)
      else $error("fault longer than one cycle");
   AST_FAULT_SOURCE: assert property (invalid_opcode_fault |-> $past(cmd_wr))
      else $error("fault without command write");
   AST_FLAG_B15: assert property (rd_acc && paddr == 8'h10 |-> !prdata[15] && prdata[1])
      else $error("flag bit 15 or bit 1 wrong");
   AST_RF_FIXED: assert property (rd_acc && paddr == 8'h10 |-> !prdata[16])
      else $error("resume flag changed");
   AST_INF_DISTINCT: assert property (rd_acc && paddr == 8'h30 |->
      (prdata == 32'h0 || prdata == 32'hFF800000))
      else $error("negative infinity pattern wrong");
   AST_IRQ_MASK: assert property (psel && penable && pwrite && paddr == 8'h3C
      && pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq high with all sources masked");
   COV_FAULT: cover property (invalid_opcode_fault);
   COV_IRQ: cover property ($rose(irq));
   COV_SLVERR: cover property (pslverr);
endmodule // status_flag_unit_chk

bind status_flag_unit status_flag_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .invalid_opcode_fault(invalid_opcode_fault));
`default_nettype wire

// ---- tb/status_flag_unit_tb.sv ----
`default_nettype none
module status_flag_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, prdata_nq, rd, rd_nq, seed, m_flags, r;
   logic        pready, pslverr, irq, fault, fault_nq, err_seen, f_seen, f_nq_seen;
   int          err_total, checks, i, j;
   logic [3:0]  ops [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
   logic [31:0] leafs [0:3] = '{32'h0, 32'h1, 32'h2, 32'h7};
   logic [31:0] q_t [0:3][0:3] = '{'{32'h2, 32'h6D617845, 32'h5865726F, 32'h43656C70},
      '{32'h610, 32'h1, 32'h0, 32'h1}, '{32'h1, 32'h0, 32'h0, 32'h0}, '{32'h0, 32'h0, 32'h0, 32'h0}};
   logic [31:0] fpu_t [0:3] = '{32'hFFFF037F, 32'h00010000, 32'h7F800000, 32'hFF800000};

   status_flag_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .invalid_opcode_fault(fault));
   // no query support, fixed alignment flag
   status_flag_unit #(.QUERY_SUPPORTED(0), .AC_IMPLEMENTED(0)) dut_nq (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata_nq), .pready(), .pslverr(), .irq(),
      .invalid_opcode_fault(fault_nq));

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ----
   // helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] exp_cmd(input logic [31:0] f, a, b, input logic [3:0] op,
      input logic [2:0] ctl, output logic [31:0] res);
      logic [32:0] s;
      logic [31:0] m;
      s = {1'b0, a} + {1'b0, b} + {32'h0, (op == 4'h3) & f[0]};
      res = (op == 4'h1) ? (a & b) : s[31:0];
      if (op inside {4'h1, 4'h2, 4'h3})
      begin
         f[7] = res[31];
         f[6] = (res == 32'h0);
         f[2] = ~^res[7:0];
         f[0] = (op == 4'h1) ? 1'b0 : s[32];
         f[11] = (op == 4'h1) ? 1'b0 : (a[31] == b[31]) && (res[31] != a[31]);
         if (op != 4'h1) f[4] = a[4] ^ b[4] ^ res[4];
      end
      m = 32'h00244FD5;
      if (!ctl[2] || ctl[1:0] == 2'h0) m = m | 32'h3000;
      if (ctl[2] && ctl[1:0] > f[13:12]) m[9] = 1'b0;
      if (op == 4'h4) f = (f & ~m) | (a & m);
      if (op == 4'h7) f[0] = 1'b0;
      if (op == 4'h8) f[0] = 1'b1;
      if (op == 4'h9) f[0] = ~f[0];
      f[1] = 1'b1;
      return f;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rd_nq = prdata_nq;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // fault pulse stands for the cycle after the command write
      @(negedge pclk);
      f_seen = fault;
      f_nq_seen = fault_nq;
      @(posedge pclk);
   endtask

   task automatic do_cmd(input logic [2:0] ctl, input logic [31:0] a, b, input logic [3:0] op);
      apb(1'b1, 8'h00, {29'h0, ctl});
      apb(1'b1, 8'h04, a);
      apb(1'b1, 8'h08, b);
      apb(1'b1, 8'h0C, {28'h0, op});
      m_flags = exp_cmd(m_flags, a, b, op, ctl, r);
      apb(1'b0, 8'h10, 32'h0);
      check("flags", rd, m_flags);
      check("flags_nq", rd_nq, m_flags & 32'hFFDBFFFF);
      if (op inside {4'h1, 4'h2, 4'h3})
      begin
         apb(1'b0, 8'h14, 32'h0);
         check("result_a", rd, r);
      end
   endtask

   task automatic test_done;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      test_done;
   end

   // ----
   // main sequence
   // ----
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      err_total = 0;
      checks = 0;
      seed = 32'h308D0F2C;
      m_flags = 32'h00000002;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      check("flags_reset", rd, 32'h00000002);
      check("pready_high", pready, 1'b1);
      apb(1'b0, 8'h2C, 32'h0);
      check("inf_before_init", rd, 32'h0);
      do_cmd(3'h0, 32'hFFFFFFFF, 32'h0, 4'h4);
      do_cmd(3'h0, 32'h0, 32'h0, 4'h4);
      do_cmd(3'h0, 32'hFFFFFFFF, 32'h1, 4'h2);
      do_cmd(3'h0, 32'h7FFFFFFF, 32'h0, 4'h3);
      apb(1'b1, 8'h38, 32'h7);
      apb(1'b1, 8'h3C, 32'h1);
      do_cmd(3'h0, 32'h0, 32'h0, 4'h0);
      check("irq_done", irq, 1'b1);
      apb(1'b1, 8'h3C, 32'h0);
      check("irq_masked", irq, 1'b0);
      apb(1'b1, 8'h3C, 32'h1);
      apb(1'b1, 8'h38, 32'h1);
      check("irq_cleared", irq, 1'b0);
      do_cmd(3'h7, 32'h00003000, 32'h0, 4'h4);
      apb(1'b0, 8'h34, 32'h0);
      check("io_privilege_field_refused", rd & 32'h4, 32'h4);
      check("io_privilege_field_no_fault", rd & 32'h2, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, 8'h04, leafs[i]);
         apb(1'b1, 8'h0C, 32'h5);
         check("query_fault", f_seen, 1'b0);
         check("query_fault_nq", f_nq_seen, 1'b1);
         for (j = 0; j < 4; j++)
         begin
            apb(1'b0, 8'(8'h14 + 4 * j), 32'h0);
            check("query_word", rd, q_t[i][j]);
         end
      end
      apb(1'b1, 8'h0C, 32'hF);
      check("bad_op_fault", f_seen, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      check("flags_after_fault", rd, m_flags);
      apb(1'b1, 8'h0C, 32'h6);
      for (i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(8'h24 + 4 * i), 32'h0);
         check("fpu_init", rd, fpu_t[i]);
      end
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped_err", err_seen, 1'b1);
      apb(1'b1, 8'h13, 32'h5);
      check("unaligned_err", err_seen, 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      check("cmd_reads_zero", rd, 32'h0);
      repeat (40)
      begin
         seed = lfsr(seed);
         r = lfsr(seed);
         do_cmd(seed[2:0], r, lfsr(r), ops[seed[5:3]]);
         seed = lfsr(lfsr(r));
      end
      test_done;
   end
endmodule // status_flag_unit_tb
`default_nettype wire
